/* src/zcd_pkg.sv */
// package of register offsets, field positions and reset values
package zcd_pkg;
    // ****************************************
    // register byte addresses on the apb bus
    // ****************************************
    localparam logic [7:0] ADDR_CONTROL = 8'h00;    // zero_cross_control
    localparam logic [7:0] ADDR_IRQ_ENABLE_THREE = 8'h04; // enable three
    localparam logic [7:0] ADDR_IRQ_FLAG_THREE = 8'h08;   // flag three
    localparam logic [7:0] ADDR_INTCON = 8'h0C;     // master and global enable
    localparam logic [7:0] ADDR_EVT_STATUS = 8'h10; // sticky event status
    localparam logic [7:0] ADDR_EVT_ENABLE = 8'h14; // event enable
    localparam logic [7:0] ADDR_EVT_CLEAR = 8'h18;  // event clear, write only
    // ****************************************
    // control and interrupt register field positions
    // ****************************************
    localparam int BIT_ENABLE = 7;   // detector_enable
    localparam int BIT_PIN_OE = 6;   // pin_output_enable
    localparam int BIT_STATUS = 5;   // logic_level_status
    localparam int BIT_POLARITY = 4; // output_polarity_invert
    localparam int BIT_RISE_EN = 1;  // rising_edge_irq_enable
    localparam int BIT_FALL_EN = 0;  // falling_edge_irq_enable
    localparam int BIT_ZC_IRQ = 4;   // flag and enable in the irq registers
    localparam int BIT_GLOBAL = 7;   // global_irq_enable in intcon
    localparam int BIT_PERIPH = 6;   // peripheral_irq_master_enable
    // ****************************************
    // event status layout
    // ****************************************
    localparam int EVT_RISE = 0;     // rising edge seen
    localparam int EVT_FALL = 1;     // falling edge seen
    localparam int EVT_POL = 2;      // polarity changed
    localparam int EVT_WIDTH = 3;    // number of events
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_CONTROL = 8'h00; // enable comes from config
    localparam logic [7:0] RST_IRQ_ENABLE_THREE = 8'h00;
    localparam logic [7:0] RST_IRQ_FLAG_THREE = 8'h00;
    localparam logic [7:0] RST_INTCON = 8'h00;
endpackage

/* src/zcd_level_sync.sv */
// two-stage synchronizer for the comparator level
`timescale 1ns/1ns
module zcd_level_sync (
    input wire logic clk,
    input wire logic nrst,
    input wire logic async_in,
    output logic sync_out
);
    logic stage_one; // first stage, read only by the second
    // ****************************************
    // two flip-flops in series
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage_one <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end
endmodule

/* src/zcd_edge_detect.sv */
// rising and falling edge detector on a synchronous level
`timescale 1ns/1ns
module zcd_edge_detect (
    input wire logic clk,
    input wire logic nrst,
    input wire logic level,
    output logic rise,
    output logic fall
);
    logic last_level; // level one clock ago
    // ****************************************
    // remember previous level
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            last_level <= 1'b0;
        end else begin
            last_level <= level;
        end
    end
    // one-cycle pulses on each transition
    assign rise = level & ~last_level;
    assign fall = ~level & last_level;
endmodule

/* src/zero_cross_event_logic.sv */
// zero-cross detector control, status and interrupt logic
//
// Overview of operation
// [R01] either enabled edge detector sets flag
// [R02] rising enable bit 1 gates rising edges
// [R03] falling enable bit 0 gates falling edges
// [R04] interrupt needs flag and all three enables set
// [R05] polarity change raises event even when disabled
// [R06] software must clear the flag itself
// [R07] edge during clear keeps flag set
// [R08] logic keeps running during processor sleep
// [R09] config bit low powers detector up active
// [R10] config bit high needs software enable write
// [R11] enable bit 7 forces pin current drive
// [R12] bit 6 routes polarized output to pin
// [R13] bit 5 reports polarized sink/source level
// [R14] polarity bit 4 inverts the logic output
// [R15] reset clears control bits, enable from config
// [R16] flag and enable at bit 4
// [R17] synchronize comparator level with two flops
`timescale 1ns/1ns
module zero_cross_event_logic (
    input wire logic REF_CLK,
    input wire logic NRST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // analog front end
    input wire logic SINK_ACTIVE,
    input wire logic DEFAULT_OFF_CONFIG_N,
    input wire logic SLEEP,
    input wire logic PORT_TRISTATE_CONTROL,
    output logic FRONT_END_ENABLE,
    output logic PIN_FORCE_DRIVE,
    output logic PIN_OUT,
    output logic PIN_OUT_OE,
    // interrupts
    output logic CPU_IRQ,
    output logic EVENT_IRQ
);
    // ****************************************
    // register state
    // ****************************************
    logic detector_enable;          // control bit 7
    logic pin_output_enable;        // control bit 6
    logic output_polarity_invert;   // control bit 4
    logic rising_edge_irq_enable;   // control bit 1
    logic falling_edge_irq_enable;  // control bit 0
    logic zero_cross_irq_enable;    // irq enable three, bit 4
    logic zero_cross_irq_flag;      // irq flag three, bit 4
    logic global_irq_enable;        // intcon bit 7
    logic peripheral_irq_master_enable; // intcon bit 6
    logic [2:0] evt_status;         // sticky event bits
    logic [2:0] evt_enable;         // event enables
    logic config_seen;              // config sampled after reset
    // ****************************************
    // derived signals
    // ****************************************
    logic raw_sync;                 // synchronized sink indication
    logic polarized_logic_output;   // level after polarity
    logic rise;                     // rising edge pulse
    logic fall;                     // falling edge pulse
    logic wr_access;                // write completes this cycle
    logic rd_access;                // read completes this cycle
    logic hit_control;
    logic hit_irq_en;
    logic hit_irq_flag;
    logic hit_intcon;
    logic hit_status;
    logic hit_enable;
    logic hit_clear;
    logic addr_ok;                  // address maps to a register
    logic edge_event;               // enabled edge seen
    logic pol_change;               // write changes the polarity
    logic [2:0] evt_set;            // new events this cycle
    logic next_flag;
    logic [31:0] next_prdata;
    logic [7:0] control_view;

    // ****************************************
    // front end path
    // ****************************************
    // sleep is deliberately not an input to any logic here
    zcd_level_sync u_sync ( // [R17]
        .clk(REF_CLK),
        .nrst(NRST),
        .async_in(SINK_ACTIVE),
        .sync_out(raw_sync)
    );
    // invert ahead of status, pin and edges
    assign polarized_logic_output =
        raw_sync ^ output_polarity_invert; // [R14]
    zcd_edge_detect u_edge (
        .clk(REF_CLK),
        .nrst(NRST),
        .level(polarized_logic_output),
        .rise(rise),
        .fall(fall)
    );
    // current drive forced while enabled, else tristate governs
    assign FRONT_END_ENABLE = detector_enable; // [R08]
    assign PIN_FORCE_DRIVE = detector_enable; // [R11]
    assign PIN_OUT = polarized_logic_output;
    assign PIN_OUT_OE = pin_output_enable; // [R12]

    // ****************************************
    // apb decode
    // ****************************************
    assign PREADY = 1'b1;
    assign wr_access = PSEL & PENABLE & PWRITE;
    assign rd_access = PSEL & PENABLE & ~PWRITE;
    assign hit_control = (PADDR == zcd_pkg::ADDR_CONTROL);
    assign hit_irq_en = (PADDR == zcd_pkg::ADDR_IRQ_ENABLE_THREE);
    assign hit_irq_flag = (PADDR == zcd_pkg::ADDR_IRQ_FLAG_THREE);
    assign hit_intcon = (PADDR == zcd_pkg::ADDR_INTCON);
    assign hit_status = (PADDR == zcd_pkg::ADDR_EVT_STATUS);
    assign hit_enable = (PADDR == zcd_pkg::ADDR_EVT_ENABLE);
    assign hit_clear = (PADDR == zcd_pkg::ADDR_EVT_CLEAR);
    assign addr_ok = hit_control | hit_irq_en | hit_irq_flag | hit_intcon |
        hit_status | hit_enable | hit_clear;
    // unmapped address answers with an error
    assign PSLVERR = PSEL & PENABLE & ~addr_ok;

    // ****************************************
    // event logic
    // ****************************************
    assign edge_event = (rise & rising_edge_irq_enable) | // [R02]
        (fall & falling_edge_irq_enable); // [R03]
    // any polarity change is an event regardless of enable
    assign pol_change = wr_access & hit_control &
        (PWDATA[zcd_pkg::BIT_POLARITY] != output_polarity_invert); // [R05]
    // set wins over software clear
    always_comb begin
        next_flag = zero_cross_irq_flag;
        if (wr_access && hit_irq_flag) begin
            next_flag = PWDATA[zcd_pkg::BIT_ZC_IRQ]; // [R06]
        end
        if (edge_event || pol_change) begin
            next_flag = 1'b1; // [R01] [R07]
        end
    end
    assign evt_set = {pol_change, fall, rise};

    // interrupt needs every enable in the chain
    assign CPU_IRQ = zero_cross_irq_flag & zero_cross_irq_enable &
        peripheral_irq_master_enable & global_irq_enable; // [R04]
    assign EVENT_IRQ = |(evt_status & evt_enable);

    // ****************************************
    // control register
    // ****************************************
    // enable follows the strap, sampled once after reset release
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            detector_enable <= 1'b0; // [R15]
            config_seen <= 1'b0;
        end else if (!config_seen) begin
            detector_enable <= ~DEFAULT_OFF_CONFIG_N; // [R09] [R10]
            config_seen <= 1'b1;
        end else if (wr_access && hit_control) begin
            detector_enable <= PWDATA[zcd_pkg::BIT_ENABLE];
        end
    end
    // remaining control bits clear on reset
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            pin_output_enable <= zcd_pkg::RST_CONTROL[zcd_pkg::BIT_PIN_OE];
            output_polarity_invert <=
                zcd_pkg::RST_CONTROL[zcd_pkg::BIT_POLARITY];
            rising_edge_irq_enable <=
                zcd_pkg::RST_CONTROL[zcd_pkg::BIT_RISE_EN];
            falling_edge_irq_enable <=
                zcd_pkg::RST_CONTROL[zcd_pkg::BIT_FALL_EN]; // [R15]
        end else if (wr_access && hit_control) begin
            pin_output_enable <= PWDATA[zcd_pkg::BIT_PIN_OE];
            output_polarity_invert <= PWDATA[zcd_pkg::BIT_POLARITY];
            rising_edge_irq_enable <= PWDATA[zcd_pkg::BIT_RISE_EN];
            falling_edge_irq_enable <= PWDATA[zcd_pkg::BIT_FALL_EN];
        end
    end

    // ****************************************
    // interrupt enables and flag
    // ****************************************
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            zero_cross_irq_enable <=
                zcd_pkg::RST_IRQ_ENABLE_THREE[zcd_pkg::BIT_ZC_IRQ];
            zero_cross_irq_flag <=
                zcd_pkg::RST_IRQ_FLAG_THREE[zcd_pkg::BIT_ZC_IRQ];
            global_irq_enable <= zcd_pkg::RST_INTCON[zcd_pkg::BIT_GLOBAL];
            peripheral_irq_master_enable <=
                zcd_pkg::RST_INTCON[zcd_pkg::BIT_PERIPH];
        end else begin
            zero_cross_irq_flag <= next_flag; // [R16]
            if (wr_access && hit_irq_en) begin
                zero_cross_irq_enable <= PWDATA[zcd_pkg::BIT_ZC_IRQ];
            end
            if (wr_access && hit_intcon) begin
                global_irq_enable <= PWDATA[zcd_pkg::BIT_GLOBAL];
                peripheral_irq_master_enable <= PWDATA[zcd_pkg::BIT_PERIPH];
            end
        end
    end

    // ****************************************
    // sticky event status
    // ****************************************
    // set beats clear in the same cycle
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            evt_status <= 3'h0;
            evt_enable <= 3'h0;
        end else begin
            if (wr_access && hit_clear) begin
                evt_status <= (evt_status & ~PWDATA[2:0]) | evt_set;
            end else begin
                evt_status <= evt_status | evt_set;
            end
            if (wr_access && hit_enable) begin
                evt_enable <= PWDATA[2:0];
            end
        end
    end

    // ****************************************
    // read data
    // ****************************************
    assign control_view = {detector_enable, pin_output_enable,
        polarized_logic_output, output_polarity_invert, 2'b00,
        rising_edge_irq_enable, falling_edge_irq_enable}; // [R13]
    always_comb begin
        next_prdata = 32'h0;
        if (hit_control) begin
            next_prdata = {24'h0, control_view};
        end else if (hit_irq_en) begin
            next_prdata = {27'h0, zero_cross_irq_enable, 4'h0};
        end else if (hit_irq_flag) begin
            next_prdata = {27'h0, zero_cross_irq_flag, 4'h0};
        end else if (hit_intcon) begin
            next_prdata = {24'h0, global_irq_enable,
                peripheral_irq_master_enable, 6'h0};
        end else if (hit_status) begin
            next_prdata = {29'h0, evt_status};
        end else if (hit_enable) begin
            next_prdata = {29'h0, evt_enable};
        end
    end
    // data taken in setup, stable during access
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            PRDATA <= 32'h0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= next_prdata;
        end else if (rd_access) begin
            PRDATA <= PRDATA;
        end
    end
endmodule

/* tb/zcd_front_model.sv */
// behavioural model of the analog sink/source front end
`timescale 1ns/1ns
module zcd_front_model (
    input wire logic clk,
    input wire logic enable,
    input wire logic want_sink,
    output logic sink_active
);
    // ****************************************
    // comparator level
    // ****************************************
    logic lvl = 1'b0; // last level shown to the block
    assign sink_active = lvl;
    // the level is only meaningful while the pin is forced to drive
    always_ff @(posedge clk) begin
        if (enable) begin
            lvl <= want_sink;
        end else begin
            lvl <= !lvl; // undriven pin chatters
        end
    end
endmodule

/* tb/zero_cross_event_logic_asserts.sv */
// assertions on the zero-cross block ports
`timescale 1ns/1ns
module zero_cross_event_logic_asserts (
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic SINK_ACTIVE,
    input wire logic DEFAULT_OFF_CONFIG_N,
    input wire logic FRONT_END_ENABLE,
    input wire logic PIN_FORCE_DRIVE,
    input wire logic PIN_OUT,
    input wire logic PIN_OUT_OE,
    input wire logic CPU_IRQ,
    input wire logic EVENT_IRQ
);
    // ****************************************
    // shadows of written controls
    // ****************************************
    logic wr; // completed write
    logic mapped; // address hits a register
    logic armed_r; // rising path fully enabled
    logic armed_f; // falling path fully enabled
    logic [2:0] since_rst; // edges since reset, saturating
    logic [7:0] ctl, pie, intc, een; // written values
    assign wr = PSEL && PENABLE && PWRITE && PREADY;
    assign mapped = (PADDR[1:0] == 2'h0) && (PADDR <= 8'h18);
    assign armed_r = (since_rst == 3'h3) && ctl[1] && pie[4] &&
        intc[7:6] == 2'h3;
    assign armed_f = (since_rst == 3'h3) && ctl[0] && pie[4] &&
        intc[7:6] == 2'h3;
    // track the writes the design must also take
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            {since_rst, ctl, pie, intc, een} <= '0;
        end else begin
            if (since_rst != 3'h3) since_rst <= since_rst + 3'h1;
            if (wr && PADDR == zcd_pkg::ADDR_CONTROL) ctl <= PWDATA[7:0];
            if (wr && PADDR == zcd_pkg::ADDR_IRQ_ENABLE_THREE) begin
                pie <= PWDATA[7:0];
            end
            if (wr && PADDR == zcd_pkg::ADDR_INTCON) intc <= PWDATA[7:0];
            if (wr && PADDR == zcd_pkg::ADDR_EVT_ENABLE) een <= PWDATA[7:0];
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    sequence s_rise_armed;
        $rose(PIN_OUT) && armed_r;
    endsequence
    sequence s_fall_armed;
        $fell(PIN_OUT) && armed_f;
    endsequence
    chk_ready_high: assert property (PREADY) else $error("ready low");
    chk_slverr_map: assert property (PSEL && PENABLE |-> PSLVERR == !mapped)
        else $error("slave error wrong");
    chk_force_drive: assert property (
        PIN_FORCE_DRIVE == FRONT_END_ENABLE) else $error("force drive wrong");
    chk_oe_follows: assert property (PIN_OUT_OE == ctl[6])
        else $error("pin enable wrong");
    chk_pin_polar: assert property (since_rst == 3'h3 |->
        PIN_OUT == ($past(SINK_ACTIVE, 2) ^ ctl[4])) else $error("pin level");
    chk_enable_strap: assert property (since_rst == 3'h1 |->
        FRONT_END_ENABLE == !DEFAULT_OFF_CONFIG_N) else $error("strap wrong");
    chk_cpu_gate: assert property (
        CPU_IRQ |-> pie[4] && intc[7:6] == 2'h3) else $error("irq not gated");
    chk_rise_flag: assert property (
        s_rise_armed |-> ##[0:2] CPU_IRQ) else $error("rise lost");
    chk_fall_flag: assert property (
        s_fall_armed |-> ##[0:2] CPU_IRQ) else $error("fall lost");
    chk_event_seen: assert property ($rose(PIN_OUT) && een[0] &&
        since_rst == 3'h3 |-> ##[0:2] EVENT_IRQ) else $error("event lost");
endmodule

/* tb/zero_cross_event_logic_tb.sv */
// self-checking bench for the zero-cross event logic
`timescale 1ns/1ns
module zero_cross_event_logic_tb;
    // ****************************************
    // signals
    // ****************************************
    logic REF_CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic SINK_ACTIVE, DEFAULT_OFF_CONFIG_N, SLEEP, PORT_TRISTATE_CONTROL;
    logic FRONT_END_ENABLE, PIN_FORCE_DRIVE, PIN_OUT, PIN_OUT_OE;
    logic CPU_IRQ, EVENT_IRQ, err, want_sink;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    int n_mismatch = 0;
    int num_checks = 0;
    zero_cross_event_logic dut_u (.REF_CLK(REF_CLK), .NRST(NRST),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .SINK_ACTIVE(SINK_ACTIVE),
        .DEFAULT_OFF_CONFIG_N(DEFAULT_OFF_CONFIG_N), .SLEEP(SLEEP),
        .PORT_TRISTATE_CONTROL(PORT_TRISTATE_CONTROL),
        .FRONT_END_ENABLE(FRONT_END_ENABLE),
        .PIN_FORCE_DRIVE(PIN_FORCE_DRIVE), .PIN_OUT(PIN_OUT),
        .PIN_OUT_OE(PIN_OUT_OE), .CPU_IRQ(CPU_IRQ), .EVENT_IRQ(EVENT_IRQ));
    zcd_front_model front_u (.clk(REF_CLK), .enable(FRONT_END_ENABLE),
        .want_sink(want_sink), .sink_active(SINK_ACTIVE));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic close_out();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, returns on a settled negative edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge REF_CLK);
            if (PREADY === 1'b1) break;
        end
        if (n == 50) begin
            n_mismatch++;
            close_out();
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(negedge REF_CLK);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    // reset with a given strap, check reset values
    task automatic t_strap(input logic cfg);
        DEFAULT_OFF_CONFIG_N <= cfg;
        NRST <= 1'b0;
        repeat (8) @(posedge REF_CLK);
        NRST <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        apb(1'b0, zcd_pkg::ADDR_CONTROL, 32'h0);
        chk(rd & 32'hFFFFFFDF, cfg ? 32'h0 : 32'h80);
        apb(1'b0, 8'h1C, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1'b1, zcd_pkg::ADDR_CONTROL, 32'h80);
        apb(1'b0, zcd_pkg::ADDR_CONTROL, 32'h0);
        chk(rd[7], 1'b1);
        chk({FRONT_END_ENABLE, PIN_FORCE_DRIVE}, 32'h3);
    endtask
    // status bit, polarity and pin output
    task automatic t_level();
        want_sink <= 1'b1;
        repeat (6) @(posedge REF_CLK);
        apb(1'b0, zcd_pkg::ADDR_CONTROL, 32'h0);
        chk({rd[5], PIN_OUT}, 32'h3);
        apb(1'b1, zcd_pkg::ADDR_CONTROL, 32'hD0);
        repeat (3) @(posedge REF_CLK);
        apb(1'b0, zcd_pkg::ADDR_CONTROL, 32'h0);
        chk({rd[5], PIN_OUT, PIN_OUT_OE}, 32'h1);
    endtask
    // edge gating and the full interrupt path, asleep
    task automatic t_rise();
        apb(1'b1, zcd_pkg::ADDR_IRQ_ENABLE_THREE, 32'h10);
        apb(1'b1, zcd_pkg::ADDR_INTCON, 32'hC0);
        apb(1'b1, zcd_pkg::ADDR_CONTROL, 32'h82);
        repeat (6) @(posedge REF_CLK);
        apb(1'b1, zcd_pkg::ADDR_IRQ_FLAG_THREE, 32'h0);
        SLEEP <= 1'b1;
        want_sink <= 1'b0;
        repeat (6) @(posedge REF_CLK);
        apb(1'b0, zcd_pkg::ADDR_IRQ_FLAG_THREE, 32'h0);
        chk({rd[4], CPU_IRQ}, 32'h0);
        want_sink <= 1'b1;
        repeat (10) @(posedge REF_CLK);
        chk(CPU_IRQ, 1'b1);
        apb(1'b1, zcd_pkg::ADDR_INTCON, 32'h80);
        chk(CPU_IRQ, 1'b0);
        apb(1'b1, zcd_pkg::ADDR_IRQ_FLAG_THREE, 32'h0);
        apb(1'b0, zcd_pkg::ADDR_IRQ_FLAG_THREE, 32'h0);
        chk(rd, 32'h0);
        SLEEP <= 1'b0;
    endtask
    // polarity change flags even while disabled
    task automatic t_pol();
        apb(1'b1, zcd_pkg::ADDR_CONTROL, 32'h00);
        apb(1'b1, zcd_pkg::ADDR_IRQ_FLAG_THREE, 32'h0);
        apb(1'b1, zcd_pkg::ADDR_CONTROL, 32'h10);
        apb(1'b0, zcd_pkg::ADDR_IRQ_FLAG_THREE, 32'h0);
        chk(rd, 32'h10);
    endtask
    // sticky events, mask and clear
    task automatic t_events();
        apb(1'b1, zcd_pkg::ADDR_CONTROL, 32'h80);
        want_sink <= 1'b0;
        repeat (6) @(posedge REF_CLK);
        apb(1'b1, zcd_pkg::ADDR_EVT_CLEAR, 32'h7);
        apb(1'b1, zcd_pkg::ADDR_EVT_ENABLE, 32'h1);
        chk(EVENT_IRQ, 1'b0);
        want_sink <= 1'b1;
        repeat (6) @(posedge REF_CLK);
        apb(1'b0, zcd_pkg::ADDR_EVT_STATUS, 32'h0);
        chk({rd[0], EVENT_IRQ}, 32'h3);
        apb(1'b1, zcd_pkg::ADDR_EVT_ENABLE, 32'h0);
        chk(EVENT_IRQ, 1'b0);
        apb(1'b1, zcd_pkg::ADDR_EVT_ENABLE, 32'h1);
        apb(1'b1, zcd_pkg::ADDR_EVT_CLEAR, 32'h1);
        apb(1'b0, zcd_pkg::ADDR_EVT_STATUS, 32'h0);
        chk({rd[0], EVENT_IRQ}, 32'h0);
    endtask
    // ****************************************
    // clock and main sequence
    // ****************************************
    initial begin
        REF_CLK = 1'b0;
        forever #20 REF_CLK = !REF_CLK;
    end
    initial begin
        {NRST, PSEL, PENABLE, PWRITE, SLEEP, want_sink} = '0;
        {PORT_TRISTATE_CONTROL, DEFAULT_OFF_CONFIG_N} = '0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        t_strap(1'b1);
        t_strap(1'b0);
        t_level();
        t_rise();
        t_pol();
        t_events();
        close_out();
    end
endmodule
bind zero_cross_event_logic zero_cross_event_logic_asserts chk_u (
    .REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SINK_ACTIVE(SINK_ACTIVE),
    .DEFAULT_OFF_CONFIG_N(DEFAULT_OFF_CONFIG_N),
    .FRONT_END_ENABLE(FRONT_END_ENABLE), .PIN_FORCE_DRIVE(PIN_FORCE_DRIVE),
    .PIN_OUT(PIN_OUT), .PIN_OUT_OE(PIN_OUT_OE), .CPU_IRQ(CPU_IRQ),
    .EVENT_IRQ(EVENT_IRQ));
